// ==== common/ifs_pkg.sv ====
// Behaviour
// - Status bit 2 is high while the transmit queue is full, clears by itself otherwise, resets to zero.
// - A processor write into the already full transmit queue sets the overrun flag at bit 3.
// - On an overrun the written word is dropped; the words already queued stay intact and still leave in order.
// - The overrun flag stays set until software writes a one to its bit of the interrupt clear register.
// - Status bit 4 is high while the receive queue is empty, resets to one, clears once it holds data.
// - Status bit 5 is high while the receive entry count is at or above the programmed threshold.
// - Status bit 6 is high while the receive queue is full, resets to zero, clears once data is read.
package ifs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Queue geometry
    localparam int unsigned DATA_W = 8;
    localparam int unsigned DEPTH = 8;
    localparam int unsigned PTR_W = 3;
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
    localparam logic [PTR_W-1:0] PTR_ZERO = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RX_THR = 8'h0C;
    localparam logic [7:0] OFF_TX_DATA = 8'h10;
    localparam logic [7:0] OFF_RX_DATA = 8'h18;
    localparam logic [7:0] OFF_RAW = 8'h30;
    localparam logic [7:0] OFF_MASK = 8'h34;
    localparam logic [7:0] OFF_EVENT = 8'h38;
    localparam logic [7:0] OFF_CLEAR = 8'h3C;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int unsigned BIT_FLUSH = 0;
    localparam int unsigned BIT_TX_FULL = 2;
    localparam int unsigned BIT_TXOVR = 3;
    localparam int unsigned BIT_RX_EMPTY = 4;
    localparam int unsigned BIT_RXNF = 5;
    localparam int unsigned BIT_RX_FULL = 6;
    localparam int unsigned THR_W = 4;
    localparam logic [THR_W-1:0] THR_RST = 4'h4;
    localparam logic [31:0] FLAG_FIELDS = 32'h0000_007C;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_ANSWER = 2'b10
    } ifs_apb_phase_t;

endpackage

// ==== hdl/ifs_fifo_flags.sv ====
`timescale 1ns/10ps
module ifs_fifo_flags import ifs_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Protocol engine, transmit side
    input wire logic tx_pop,
    output logic [DATA_W-1:0] tx_byte,
    output logic tx_byte_valid,
    // Protocol engine, receive side
    input wire logic rx_push,
    input wire logic [DATA_W-1:0] rx_byte,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    function automatic logic [CNT_W-1:0] cnt_next(input logic [CNT_W-1:0] cnt,
                                                  input logic inc, input logic dec);
        logic [CNT_W-1:0] res;
        res = cnt;
        if (inc && !dec) begin
            res = cnt + CNT_ONE;
        end else if (dec && !inc) begin
            res = cnt - CNT_ONE;
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State
    ifs_apb_phase_t phase_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [DATA_W-1:0] tx_mem_q [DEPTH];
    logic [DATA_W-1:0] rx_mem_q [DEPTH];
    logic [PTR_W-1:0] tx_wp_q;
    logic [PTR_W-1:0] tx_rp_q;
    logic [CNT_W-1:0] tx_cnt_q;
    logic [PTR_W-1:0] rx_wp_q;
    logic [PTR_W-1:0] rx_rp_q;
    logic [CNT_W-1:0] rx_cnt_q;
    logic [THR_W-1:0] thr_q;
    logic [31:0] mask_q;
    logic [31:0] evt_q;
    logic tx_full_flag_q;
    logic ovr_q;
    logic rx_empty_flag_q;
    logic rxnf_q;
    logic rx_full_flag_q;
    logic [DATA_W-1:0] tx_byte_q;
    logic tx_byte_valid_q;
    logic irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus phase decode
    wire setup = psel & ~penable & (phase_q == PH_IDLE);
    wire done = psel & penable & pready_q;
    wire wr_done = done & pwrite;
    wire rd_done = done & ~pwrite;
    wire hit_ctrl = hit(paddr, OFF_CTRL);
    wire hit_thr = hit(paddr, OFF_RX_THR);
    wire hit_txd = hit(paddr, OFF_TX_DATA);
    wire hit_rxd = hit(paddr, OFF_RX_DATA);
    wire hit_raw = hit(paddr, OFF_RAW);
    wire hit_mask = hit(paddr, OFF_MASK);
    wire hit_evt = hit(paddr, OFF_EVENT);
    wire hit_clear = hit(paddr, OFF_CLEAR);
    wire mapped = hit_ctrl | hit_thr | hit_txd | hit_rxd | hit_raw | hit_mask | hit_evt
                  | hit_clear;

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit queue control
    wire tx_full = (tx_cnt_q == CNT_FULL);
    wire tx_empty = (tx_cnt_q == CNT_ZERO);
    wire tx_wr = wr_done & hit_txd;
    wire flush = wr_done & hit_ctrl & pwdata[BIT_FLUSH];
    // A write into a full queue is dropped; only the overrun flag records it
    wire tx_accept = tx_wr & ~tx_full;
    wire ovr_set = tx_wr & tx_full;
    wire ovr_clr = wr_done & hit_clear & pwdata[BIT_TXOVR];
    // Flush beats a simultaneous engine pull, so no byte leaves a discarded queue
    wire tx_take = tx_pop & ~tx_empty & ~flush;
    wire [CNT_W-1:0] tx_cnt_d = flush ? CNT_ZERO : cnt_next(tx_cnt_q, tx_accept, tx_take);
    wire [PTR_W-1:0] tx_wp_d = flush ? PTR_ZERO : (tx_accept ? tx_wp_q + PTR_ONE : tx_wp_q);
    wire [PTR_W-1:0] tx_rp_d = flush ? PTR_ZERO : (tx_take ? tx_rp_q + PTR_ONE : tx_rp_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Receive queue control
    wire rx_full = (rx_cnt_q == CNT_FULL);
    wire rx_empty = (rx_cnt_q == CNT_ZERO);
    // Bytes arriving at a full queue are lost; the engine should watch the full flag
    wire rx_accept = rx_push & ~rx_full;
    wire rx_rd = rd_done & hit_rxd & ~rx_empty;
    wire [CNT_W-1:0] rx_cnt_d = cnt_next(rx_cnt_q, rx_accept, rx_rd);
    wire [PTR_W-1:0] rx_wp_d = rx_accept ? rx_wp_q + PTR_ONE : rx_wp_q;
    wire [PTR_W-1:0] rx_rp_d = rx_rd ? rx_rp_q + PTR_ONE : rx_rp_q;
    wire [THR_W-1:0] thr_d = (wr_done & hit_thr) ? pwdata[THR_W-1:0] : thr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Flag next values, from queue occupancy, the receive threshold and the overrun set and clear, never from the mask
    wire tx_full_flag_d = (tx_cnt_d == CNT_FULL);
    wire ovr_d = ovr_set | (ovr_q & ~ovr_clr);
    wire rx_empty_flag_d = (rx_cnt_d == CNT_ZERO);
    wire rxnf_d = (rx_cnt_d >= CNT_W'(thr_d));
    wire rx_full_flag_d = (rx_cnt_d == CNT_FULL);

    logic [31:0] raw_word;
    logic [31:0] raw_next;
    always_comb begin
        raw_word = WORD_ZERO;
        raw_word[BIT_TX_FULL] = tx_full_flag_q;
        raw_word[BIT_TXOVR] = ovr_q;
        raw_word[BIT_RX_EMPTY] = rx_empty_flag_q;
        raw_word[BIT_RXNF] = rxnf_q;
        raw_word[BIT_RX_FULL] = rx_full_flag_q;
        raw_next = WORD_ZERO;
        raw_next[BIT_TX_FULL] = tx_full_flag_d;
        raw_next[BIT_TXOVR] = ovr_d;
        raw_next[BIT_RX_EMPTY] = rx_empty_flag_d;
        raw_next[BIT_RXNF] = rxnf_d;
        raw_next[BIT_RX_FULL] = rx_full_flag_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Events and interrupt
    // A flag rising in the same cycle as the clearing read stays latched
    wire [31:0] evt_rise = raw_next & ~raw_word & FLAG_FIELDS;
    wire [31:0] evt_clr = (rd_done & hit_evt) ? prdata_q : WORD_ZERO;
    wire [31:0] evt_d = (evt_q & ~evt_clr) | evt_rise;
    wire [31:0] mask_d = (wr_done & hit_mask) ? (pwdata & FLAG_FIELDS) : mask_q;
    wire irq_d = |(evt_d & mask_d);

    ////////////////////////////////////////////////////////////////////////////////
    // Read data select, captured in the setup cycle
    wire [31:0] rx_head = {{(32 - DATA_W){1'b0}}, rx_mem_q[rx_rp_q]};
    wire [31:0] rdata = hit_raw ? raw_word :
                        hit_mask ? mask_q :
                        hit_evt ? evt_q :
                        hit_thr ? {{(32 - THR_W){1'b0}}, thr_q} :
                        hit_rxd ? (rx_empty ? WORD_ZERO : rx_head) :
                        WORD_ZERO;

    ////////////////////////////////////////////////////////////////////////////////
    // APB answer: no wait state, pready high in the first access cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= PH_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= WORD_ZERO;
        end else begin
            case (phase_q)
                PH_IDLE: begin
                    if (setup) begin
                        phase_q <= PH_ANSWER;
                        pready_q <= 1'b1;
                        pslverr_q <= ~mapped;
                        prdata_q <= pwrite ? WORD_ZERO : rdata;
                    end
                end
                PH_ANSWER: begin
                    phase_q <= PH_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                end
                default: begin
                    phase_q <= PH_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Queue storage
    for (genvar i = 0; i < DEPTH; i++) begin : g_mem
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                tx_mem_q[i] <= '0;
                rx_mem_q[i] <= '0;
            end else begin
                if (tx_accept && tx_wp_q == PTR_W'(i)) begin
                    tx_mem_q[i] <= pwdata[DATA_W-1:0];
                end
                if (rx_accept && rx_wp_q == PTR_W'(i)) begin
                    rx_mem_q[i] <= rx_byte;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pointers, counts, flags, registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_wp_q <= PTR_ZERO;
            tx_rp_q <= PTR_ZERO;
            tx_cnt_q <= CNT_ZERO;
            rx_wp_q <= PTR_ZERO;
            rx_rp_q <= PTR_ZERO;
            rx_cnt_q <= CNT_ZERO;
            thr_q <= THR_RST;
            mask_q <= WORD_ZERO;
            evt_q <= WORD_ZERO;
            irq_q <= 1'b0;
        end else begin
            tx_wp_q <= tx_wp_d;
            tx_rp_q <= tx_rp_d;
            tx_cnt_q <= tx_cnt_d;
            rx_wp_q <= rx_wp_d;
            rx_rp_q <= rx_rp_d;
            rx_cnt_q <= rx_cnt_d;
            thr_q <= thr_d;
            mask_q <= mask_d;
            evt_q <= evt_d;
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_full_flag_q <= 1'b0;
            ovr_q <= 1'b0;
            rx_empty_flag_q <= 1'b1;
            rxnf_q <= 1'b0;
            rx_full_flag_q <= 1'b0;
        end else begin
            tx_full_flag_q <= tx_full_flag_d;
            ovr_q <= ovr_d;
            rx_empty_flag_q <= rx_empty_flag_d;
            rxnf_q <= rxnf_d;
            rx_full_flag_q <= rx_full_flag_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_byte_q <= '0;
            tx_byte_valid_q <= 1'b0;
        end else begin
            tx_byte_valid_q <= tx_take;
            if (tx_take) begin
                tx_byte_q <= tx_mem_q[tx_rp_q];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_byte = tx_byte_q;
    assign tx_byte_valid = tx_byte_valid_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_txfull_level: assert property (tx_full_flag_q == (tx_cnt_q == CNT_FULL))
        else $error("transmit full flag disagrees with occupancy");

    a_ovr_set: assert property (tx_wr && tx_full |=> ovr_q)
        else $error("overrun flag not set by write into full queue");

    a_ovr_drop: assert property (tx_wr && tx_full && !tx_take && !flush
                                 |=> tx_cnt_q == CNT_FULL)
        else $error("write into full queue was not dropped");

    a_ovr_sticky: assert property (ovr_q && !ovr_clr |=> ovr_q)
        else $error("overrun flag cleared without clear register write");

    a_ovr_clear: assert property (ovr_q && ovr_clr && !ovr_set |=> !ovr_q)
        else $error("overrun flag not cleared by clear register write");

    a_rxempty_level: assert property (rx_empty_flag_q == (rx_cnt_q == CNT_ZERO))
        else $error("receive empty flag disagrees with occupancy");

    a_rxnf_level: assert property (rxnf_q == (rx_cnt_q >= CNT_W'(thr_q)))
        else $error("receive nearly full flag disagrees with threshold");

    a_rxfull_clear: assert property (rx_full_flag_q && rx_rd && !rx_push
                                     |=> !rx_full_flag_q)
        else $error("receive full flag not cleared by a read");

    a_rxfull_level: assert property (rx_full_flag_q == (rx_cnt_q == CNT_FULL))
        else $error("receive full flag disagrees with occupancy");

    a_raw_reserved: assert property (setup && hit_raw && !pwrite
                                     |=> prdata_q[15:7] == 9'h000)
        else $error("reserved status bits read nonzero");

    a_flush_empty: assert property (flush && !ovr_set
                                    |=> tx_cnt_q == CNT_ZERO && !tx_full_flag_q
                                    && ovr_q == $past(ovr_q))
        else $error("flush did not empty queue or disturbed overrun flag");

    // Engine hand-off, interrupt and bus error
    a_rx_drop: assert property (rx_push && rx_full && !rx_rd |=> rx_cnt_q == CNT_FULL)
        else $error("byte pushed into full receive queue was kept");

    a_pop_answer: assert property (tx_take |=> tx_byte_valid_q)
        else $error("accepted pull gave no byte");

    a_pop_idle: assert property (!tx_take |=> !tx_byte_valid_q)
        else $error("byte handed out without an accepted pull");

    a_flush_no_pop: assert property (flush |=> !tx_byte_valid_q)
        else $error("byte left a flushed queue");

    a_irq_level: assert property (irq_q == |(evt_q & mask_q))
        else $error("interrupt disagrees with latched events and mask");

    a_bus_error: assert property (setup && !mapped |=> pready_q && pslverr_q)
        else $error("unmapped address gave no error");

    a_evt_sticky: assert property (evt_q[BIT_TXOVR] && !(rd_done && hit_evt) |=> evt_q[BIT_TXOVR])
        else $error("latched event lost without a read");

    a_apb_answer: assert property (setup |=> pready_q ##1 !pready_q)
        else $error("bus answer not exactly one access cycle");

    c_overrun: cover property (ovr_set ##[1:20] flush);
    c_rx_full: cover property (rx_full_flag_q ##1 rx_rd);
    c_rx_drop: cover property (rx_push && rx_full);
    c_irq: cover property ($rose(irq_q) ##[1:20] (rd_done && hit_evt));
    c_back_to_back: cover property (done ##1 setup);

endmodule // ifs_fifo_flags

// ==== verif/ifs_engine_model.sv ====
`timescale 1ns/10ps
module ifs_engine_model import ifs_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Transmit side
    output logic tx_pop,
    input wire logic [DATA_W-1:0] tx_byte,
    input wire logic tx_byte_valid,
    // Receive side
    output logic rx_push,
    output logic [DATA_W-1:0] rx_byte
);
    initial begin
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_byte = 8'h5A;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The byte is looked at only in the one cycle that it stands
    task automatic pop(output logic [DATA_W-1:0] b, output logic ok);
        @(posedge clk);
        tx_pop <= 1'b1;
        @(posedge clk);
        tx_pop <= 1'b0;
        @(posedge clk);
        b = tx_byte;
        ok = tx_byte_valid;
    endtask

    // Released data is inverted, so a stale byte never passes for a fresh one
    task automatic push(input logic [DATA_W-1:0] b);
        @(posedge clk);
        rx_push <= 1'b1;
        rx_byte <= b;
        @(posedge clk);
        rx_push <= 1'b0;
        rx_byte <= ~b;
    endtask
endmodule // ifs_engine_model

// ==== verif/i2c_fifo_status_flags_tb.sv ====
`timescale 1ns/10ps
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e); end end
module i2c_fifo_status_flags_tb;
    import ifs_pkg::*;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic tx_pop, tx_byte_valid, rx_push, irq, err, ok;
    logic [7:0] paddr, tx_byte, rx_byte, b;
    logic [31:0] pwdata, prdata, rd;
    int compares, miscompares;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ifs_fifo_flags DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_pop(tx_pop), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
        .rx_push(rx_push), .rx_byte(rx_byte), .irq(irq));
    ifs_engine_model ENG (.clk(clk), .resetn(resetn), .tx_pop(tx_pop), .tx_byte(tx_byte),
        .tx_byte_valid(tx_byte_valid), .rx_push(rx_push), .rx_byte(rx_byte));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Request held until pready is seen; only the watchdog ends a stuck wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e, m)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        chk_reg(OFF_RAW, 32'h0000_0010, "raw reset");
        chk_reg(OFF_RX_THR, 32'h0000_0004, "thr reset");
        apb(1'b1, OFF_RAW, 32'hFFFF_FFFF);
        chk_reg(OFF_RAW, 32'h0000_0010, "raw ro");
        apb(1'b0, 8'h40, 32'h0);
        `CHK(err, 1'b1, "unmapped")
        apb(1'b1, OFF_MASK, 32'h0000_007C);
        chk_reg(OFF_MASK, 32'h0000_007C, "mask rw");
        chk_reg(OFF_RAW, 32'h0000_0010, "raw masked");
        apb(1'b1, OFF_MASK, 32'h0);
    endtask

    task automatic t_tx;
        int i;
        for (i = 0; i < 8; i++) begin
            apb(1'b1, OFF_TX_DATA, 32'hA0 + i);
            if (i == 6) chk_reg(OFF_RAW, 32'h10, "tx seven");
        end
        chk_reg(OFF_RAW, 32'h14, "tx full");
        apb(1'b1, OFF_TX_DATA, 32'hEE);
        chk_reg(OFF_RAW, 32'h1C, "overrun");
        for (i = 0; i < 8; i++) begin
            ENG.pop(b, ok);
            `CHK({ok, b}, {1'b1, 8'hA0 + 8'(i)}, "pop order")
            if (i == 0) chk_reg(OFF_RAW, 32'h18, "not full");
        end
        ENG.pop(b, ok);
        `CHK(ok, 1'b0, "dropped word")
        for (i = 0; i < 8; i++) apb(1'b1, OFF_TX_DATA, 32'h55);
        apb(1'b1, OFF_CLEAR, 32'h0);
        chk_reg(OFF_RAW, 32'h1C, "icr zero");
        apb(1'b1, OFF_CTRL, 32'h1);
        chk_reg(OFF_RAW, 32'h18, "flushed");
        ENG.pop(b, ok);
        `CHK(ok, 1'b0, "flush empties")
        apb(1'b1, OFF_CLEAR, 32'h8);
        chk_reg(OFF_RAW, 32'h10, "ovr cleared");
    endtask

    task automatic t_rx;
        int i;
        apb(1'b0, OFF_EVENT, 32'h0);
        for (i = 0; i < 8; i++) begin
            ENG.push(8'hC0 + 8'(i));
            if (i == 0) chk_reg(OFF_RAW, 32'h00, "rx one");
            if (i == 2) chk_reg(OFF_RAW, 32'h00, "rx three");
            if (i == 3) chk_reg(OFF_RAW, 32'h20, "rx four");
            if (i == 6) chk_reg(OFF_RAW, 32'h20, "rx seven");
        end
        ENG.push(8'hFF);
        chk_reg(OFF_RAW, 32'h60, "rx full");
        `CHK(irq, 1'b0, "irq masked")
        apb(1'b1, OFF_MASK, 32'h40);
        chk_reg(OFF_RX_DATA, 32'hC0, "rx first");
        `CHK(irq, 1'b1, "irq up")
        chk_reg(OFF_RAW, 32'h20, "rx unfull");
        apb(1'b1, OFF_RX_THR, 32'h7);
        chk_reg(OFF_RAW, 32'h20, "at thr");
        chk_reg(OFF_RX_DATA, 32'hC1, "rx second");
        chk_reg(OFF_RAW, 32'h00, "below thr");
        chk_reg(OFF_EVENT, 32'h60, "events");
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0, "irq cleared")
        for (i = 0; i < 6; i++) apb(1'b0, OFF_RX_DATA, 32'h0);
        chk_reg(OFF_RAW, 32'h10, "rx empty");
        chk_reg(OFF_RX_DATA, 32'h0, "empty read");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        compares = 0;
        miscompares = 0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_regs;
        t_tx;
        t_rx;
        summarize;
    end

    // The tests need well under a thousand cycles; twenty thousand is ample
    initial begin
        #2_000_000;
        miscompares++;
        $display("CHECK FAILED t=%0t watchdog", $time);
        summarize;
    end
endmodule // i2c_fifo_status_flags_tb
